//--- rtl/sfre_cfg.svh
// Opcodes, phase lengths and reset values of the serial flash read engine
`ifndef SFRE_CFG_SVH
`define SFRE_CFG_SVH
`define SFRE_OP_READ     8'h03
`define SFRE_OP_FAST     8'h0b
`define SFRE_OP_DOUT     8'h3b
`define SFRE_OP_QOUT     8'h6b
`define SFRE_OP_DIO      8'hbb
`define SFRE_OP_QIO      8'heb
`define SFRE_CRM_SKIP    2'h2
`define SFRE_DUMMY_STD   5'h08
`define SFRE_DUMMY_QIO   5'h04
`define SFRE_PARAM_RST   2'h0
`define SFRE_OPC_CLK_SPI 5'h08
`define SFRE_OPC_CLK_QPI 5'h02
`define SFRE_ADR_CLK_X1  5'h18
`define SFRE_ADR_CLK_X2  5'h0c
`define SFRE_ADR_CLK_X4  5'h06
`endif

//--- rtl/sfre_pkg.sv
// Types of the serial flash read engine
package sfre_pkg;
	typedef enum logic [2:0] {
		ST_OPC,
		ST_ADR,
		ST_MOD,
		ST_DUM,
		ST_DAT,
		ST_IGN
	} sfre_state_e;
	typedef logic [2:0] sfre_width_t;
endpackage

//--- rtl/sfre_engine.sv
// Serial flash read engine: control ports, link state machine, lane drivers
`timescale 1ns/100ps
// Functional notes
// [R1] Opcode, 24-bit address sampled on rising edge
// [R2] Data shifted out MSB first on falling edges
// [R3] Address increments per byte until select rises
// [R4] Read ignored while busy flag set
// [R5] Plain read refused in four-wire mode
// [R6] Fast read: eight dummy clocks after address
// [R7] Four-wire fast read dummy from parameter field
// [R8] Parameter field resets to two dummy clocks
// [R9] Dual output: eight dummies, two lanes out
// [R10] Host floats lane zero before data
// [R11] Quad output refused unless quad enable set
// [R12] Quad output: eight dummies, four lanes out
// [R13] Dual I/O: address and data on two lanes
// [R14] Mode byte follows address, low nibble ignored
// [R15] Mode bits 5:4 = 10 skip next opcode
// [R16] Host sends ones sixteen clocks to leave dual
// [R17] Quad I/O: four lanes, four dummy clocks
// [R18] Quad I/O refused unless quad enable set
// [R19] Host sends ones eight clocks to leave quad
// [R20] Host floats shared lanes before data
// [R21] Four-wire mode: everything on four lanes
// [R22] Four-wire mode needs quad enable, locks it; entry with a same-cycle clear leaves four-wire on, quad enable off
// [R23] Two-lane pairs: lane one holds upper bit
// [R24] Exact dummy count, drive from first data edge
`include "sfre_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module sfre_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sfre_engine (
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic        busy_in,
	input  wire logic        qe_wr_in,
	input  wire logic        qe_wdata_in,
	input  wire logic        four_wire_enter_in,
	input  wire logic        four_wire_exit_in,
	input  wire logic        param_wr_in,
	input  wire logic [1:0]  param_dummy_in,
	input  wire logic        soft_reset_in,
	input  wire logic        sclk_in,
	input  wire logic        cs_n_in,
	input  wire logic        lane_zero_in,
	output wire logic        lane_zero_out,
	output wire logic        lane_zero_oe_out,
	input  wire logic        lane_one_in,
	output wire logic        lane_one_out,
	output wire logic        lane_one_oe_out,
	input  wire logic        lane_two_in,
	output wire logic        lane_two_out,
	output wire logic        lane_two_oe_out,
	input  wire logic        lane_three_in,
	output wire logic        lane_three_out,
	output wire logic        lane_three_oe_out,
	output wire logic [23:0] mem_addr_out,
	input  wire logic [7:0]  mem_data_in,
	output wire logic        quad_lane_enable_bit_out,
	output wire logic        four_wire_command_mode_out,
	output wire logic [1:0]  dummy_select_out,
	output logic             continuous_read_out,
	output logic             frame_active_out
);
	logic                  qe_q;
	logic                  qpi_q;
	logic [1:0]            param_q;
	logic                  busy_l;
	logic                  qe_l;
	logic                  qpi_l;
	logic [1:0]            param_l;
	logic                  frm_rst_n;
	sfre_pkg::sfre_state_e st_q;
	sfre_pkg::sfre_state_e st_cur;
	logic                  first_q;
	logic [4:0]            cnt_q;
	logic [23:0]           sh_q;
	logic [23:0]           sh_d;
	logic [7:0]            op_q;
	logic [7:0]            op_cur;
	logic                  crm_q;
	logic [7:0]            crm_op_q;
	logic                  crm_start;
	logic [23:0]           mem_addr_q;
	logic [3:0]            lanes;
	logic [3:0]            lane_o_q;
	logic [3:0]            lane_oe_q;
	logic [3:0]            out_bits;
	logic [3:0]            out_oe;
	logic [7:0]            shifted;
	logic [2:0]            sh_amt;
	sfre_pkg::sfre_width_t lane_w;
	sfre_pkg::sfre_width_t aw;
	sfre_pkg::sfre_width_t dw;
	logic [4:0]            phase_len;
	logic [4:0]            dummy;
	logic                  phase_end;
	logic                  legal;

	////////////////////////////////////////////////////////////////////////
	// Control bits on the system clock
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			qe_q <= 1'b0;
		else if (qe_wr_in && !qpi_q)
			qe_q <= qe_wdata_in; // [R22]
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			qpi_q <= 1'b0;
		else if (four_wire_exit_in)
			qpi_q <= 1'b0;
		else if (four_wire_enter_in && qe_q)
			qpi_q <= 1'b1; // [R22]
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in)
			param_q <= `SFRE_PARAM_RST; // [R8]
		else if (soft_reset_in)
			param_q <= `SFRE_PARAM_RST; // [R8]
		else if (param_wr_in)
			param_q <= param_dummy_in; // [R7]
	end

	assign quad_lane_enable_bit_out   = qe_q;
	assign four_wire_command_mode_out = qpi_q;
	assign dummy_select_out           = param_q;

	sfre_sync #(.W(5)) u_to_link (
		.clk_in  (sclk_in),
		.rstn_in (rstn_in),
		.d_in    ({busy_in, qe_q, qpi_q, param_q}),
		.q_out   ({busy_l, qe_l, qpi_l, param_l})
	);

	sfre_sync #(.W(2)) u_to_sys (
		.clk_in  (mclk_in),
		.rstn_in (rstn_in),
		.d_in    ({crm_q, ~cs_n_in}),
		.q_out   ({continuous_read_out, frame_active_out})
	);

	////////////////////////////////////////////////////////////////////////
	// Opcode decode helpers
	function automatic sfre_pkg::sfre_width_t addr_w(input logic [7:0] op, input logic four_wire_command_mode);
		if (four_wire_command_mode || op == `SFRE_OP_QIO)
			return 3'h4; // [R17] [R21]
		if (op == `SFRE_OP_DIO)
			return 3'h2; // [R13]
		return 3'h1;
	endfunction

	function automatic sfre_pkg::sfre_width_t data_w(input logic [7:0] op, input logic four_wire_command_mode);
		if (four_wire_command_mode || op == `SFRE_OP_QIO || op == `SFRE_OP_QOUT)
			return 3'h4; // [R12] [R17] [R21]
		if (op == `SFRE_OP_DIO || op == `SFRE_OP_DOUT)
			return 3'h2; // [R9] [R13]
		return 3'h1;
	endfunction

	function automatic logic [4:0] dummy_of(input logic [7:0] op, input logic four_wire_command_mode,
	                                        input logic [1:0] prm);
		if (four_wire_command_mode)
			return (op == `SFRE_OP_QIO) ? {2'h0, prm, 1'b0} : {2'h0, prm, 1'b0} + 5'h02; // [R7]
		if (op == `SFRE_OP_QIO)
			return `SFRE_DUMMY_QIO; // [R17]
		if (op == `SFRE_OP_FAST || op == `SFRE_OP_DOUT || op == `SFRE_OP_QOUT)
			return `SFRE_DUMMY_STD; // [R6] [R9] [R12]
		return 5'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link side, rising edge: shifter, phase counter, state
	assign frm_rst_n = rstn_in & ~cs_n_in; // [R3]
	assign lanes     = {lane_three_in, lane_two_in, lane_one_in, lane_zero_in};
	assign crm_start = (st_q == sfre_pkg::ST_OPC) && first_q && crm_q; // [R15]
	assign st_cur    = crm_start ? sfre_pkg::ST_ADR : st_q;
	assign op_cur    = crm_start ? crm_op_q : op_q;
	assign aw        = addr_w(op_cur, qpi_l);
	assign dw        = data_w(op_q, qpi_l);
	assign dummy     = dummy_of(op_cur, qpi_l, param_l);

	always_comb begin
		legal = 1'b0;
		if (qpi_l)
			legal = (sh_d[7:0] == `SFRE_OP_FAST) || (sh_d[7:0] == `SFRE_OP_QIO); // [R5]
		else
			legal = (sh_d[7:0] == `SFRE_OP_READ) || (sh_d[7:0] == `SFRE_OP_FAST) ||
			        (sh_d[7:0] == `SFRE_OP_DOUT) || (sh_d[7:0] == `SFRE_OP_DIO) ||
			        (qe_l && (sh_d[7:0] == `SFRE_OP_QOUT)) || // [R11]
			        (qe_l && (sh_d[7:0] == `SFRE_OP_QIO)); // [R18]
	end

	always_comb begin
		lane_w    = 3'h1;
		phase_len = 5'h01;
		case (st_cur)
			sfre_pkg::ST_OPC: begin
				lane_w    = qpi_l ? 3'h4 : 3'h1; // [R21]
				phase_len = qpi_l ? `SFRE_OPC_CLK_QPI : `SFRE_OPC_CLK_SPI;
			end
			sfre_pkg::ST_ADR: begin
				lane_w    = aw;
				phase_len = (aw == 3'h4) ? `SFRE_ADR_CLK_X4 :
				            (aw == 3'h2) ? `SFRE_ADR_CLK_X2 : `SFRE_ADR_CLK_X1; // [R1]
			end
			sfre_pkg::ST_MOD: begin
				lane_w    = aw;
				phase_len = (aw == 3'h4) ? 5'h02 : 5'h04; // [R14]
			end
			sfre_pkg::ST_DUM: phase_len = dummy; // [R24]
			sfre_pkg::ST_DAT: phase_len = (dw == 3'h4) ? 5'h02 : (dw == 3'h2) ? 5'h04 : 5'h08;
			default: phase_len = 5'h01;
		endcase
	end

	assign phase_end = (cnt_q == phase_len - 5'h01);

	always_comb begin
		case (lane_w)
			3'h4: sh_d = {sh_q[19:0], lanes}; // [R21]
			3'h2: sh_d = {sh_q[21:0], lanes[1:0]}; // [R23]
			default: sh_d = {sh_q[22:0], lanes[0]}; // [R1]
		endcase
	end

	always_ff @(posedge sclk_in or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			sh_q    <= 24'h000000;
			cnt_q   <= 5'h00;
			first_q <= 1'b1;
		end else begin
			sh_q    <= sh_d;
			cnt_q   <= phase_end ? 5'h00 : cnt_q + 5'h01;
			first_q <= 1'b0;
		end
	end

	always_ff @(posedge sclk_in or negedge frm_rst_n) begin
		if (!frm_rst_n)
			op_q <= 8'h00;
		else if (crm_start)
			op_q <= crm_op_q; // [R15]
		else if (st_q == sfre_pkg::ST_OPC && phase_end)
			op_q <= sh_d[7:0];
	end

	always_ff @(posedge sclk_in or negedge frm_rst_n) begin
		if (!frm_rst_n)
			st_q <= sfre_pkg::ST_OPC;
		else if (phase_end) begin
			case (st_cur)
				sfre_pkg::ST_OPC: st_q <= legal ? sfre_pkg::ST_ADR : sfre_pkg::ST_IGN;
				sfre_pkg::ST_ADR: begin
					if (busy_l)
						st_q <= sfre_pkg::ST_IGN; // [R4]
					else if (op_cur == `SFRE_OP_DIO || op_cur == `SFRE_OP_QIO)
						st_q <= sfre_pkg::ST_MOD; // [R14]
					else if (dummy != 5'h00)
						st_q <= sfre_pkg::ST_DUM; // [R6]
					else
						st_q <= sfre_pkg::ST_DAT; // [R2]
				end
				sfre_pkg::ST_MOD: st_q <= (dummy != 5'h00) ? sfre_pkg::ST_DUM : sfre_pkg::ST_DAT;
				sfre_pkg::ST_DUM: st_q <= sfre_pkg::ST_DAT; // [R24]
				default: st_q <= st_q;
			endcase
		end else if (crm_start)
			st_q <= sfre_pkg::ST_ADR; // [R15]
	end

	always_ff @(posedge sclk_in or negedge rstn_in) begin
		if (!rstn_in)
			mem_addr_q <= 24'h000000;
		else if (st_cur == sfre_pkg::ST_ADR && phase_end)
			mem_addr_q <= sh_d; // [R1]
		else if (st_q == sfre_pkg::ST_DAT && phase_end)
			mem_addr_q <= mem_addr_q + 24'h000001; // [R3]
	end

	// Survives select high so the next frame may skip its opcode
	always_ff @(posedge sclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			crm_q    <= 1'b0;
			crm_op_q <= 8'h00;
		end else if (st_q == sfre_pkg::ST_MOD && phase_end) begin
			crm_q    <= (sh_d[5:4] == `SFRE_CRM_SKIP); // [R14] [R15]
			crm_op_q <= op_q;
		end
	end

	assign mem_addr_out = mem_addr_q;

	////////////////////////////////////////////////////////////////////////
	// Link side, falling edge: lane drivers
	always_comb begin
		case (dw)
			3'h4: sh_amt = {cnt_q[0], 2'h0};
			3'h2: sh_amt = {cnt_q[1:0], 1'b0};
			default: sh_amt = cnt_q[2:0];
		endcase
		shifted = mem_data_in << sh_amt; // [R2]
		case (dw)
			3'h4: begin
				out_bits = shifted[7:4]; // [R12] [R17]
				out_oe   = 4'hf;
			end
			3'h2: begin
				out_bits = {2'h0, shifted[7:6]}; // [R23]
				out_oe   = 4'h3;
			end
			default: begin
				out_bits = {2'h0, shifted[7], 1'b0};
				out_oe   = 4'h2;
			end
		endcase
	end

	always_ff @(negedge sclk_in or negedge frm_rst_n) begin
		if (!frm_rst_n) begin
			lane_o_q  <= 4'h0;
			lane_oe_q <= 4'h0;
		end else if (st_q == sfre_pkg::ST_DAT) begin
			lane_o_q  <= out_bits; // [R2]
			lane_oe_q <= out_oe; // [R24]
		end else
			lane_oe_q <= 4'h0; // [R24]
	end

	assign lane_zero_out     = lane_o_q[0];
	assign lane_one_out      = lane_o_q[1];
	assign lane_two_out      = lane_o_q[2];
	assign lane_three_out    = lane_o_q[3];
	assign lane_zero_oe_out  = lane_oe_q[0];
	assign lane_one_oe_out   = lane_oe_q[1];
	assign lane_two_oe_out   = lane_oe_q[2];
	assign lane_three_oe_out = lane_oe_q[3];

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_OE_DATA_ONLY: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R24]
		(lane_oe_q != 4'h0) |-> (st_q == sfre_pkg::ST_DAT))
		else $error("lane driven outside data phase");
	AST_MSB_FIRST: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R2]
		(st_q == sfre_pkg::ST_DAT && $past(st_q) == sfre_pkg::ST_ADR && op_q == `SFRE_OP_READ)
		|-> (lane_o_q[1] == mem_data_in[7] && lane_oe_q == 4'h2))
		else $error("first read bit not msb");
	AST_ADDR_INC: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R3]
		(st_q == sfre_pkg::ST_DAT && phase_end) |=> (mem_addr_q == $past(mem_addr_q) + 24'h000001))
		else $error("address not advanced after byte");
	AST_BUSY_IGNORE: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R4]
		(st_cur == sfre_pkg::ST_ADR && phase_end && busy_l) |=> (st_q == sfre_pkg::ST_IGN) [*3])
		else $error("read taken while busy");
	AST_READ_QPI: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R5]
		(st_q == sfre_pkg::ST_OPC && phase_end && qpi_l && sh_d[7:0] == `SFRE_OP_READ)
		|=> (st_q == sfre_pkg::ST_IGN))
		else $error("plain read accepted in four-wire mode");
	AST_FAST_DUMMY: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R6]
		(st_q == sfre_pkg::ST_ADR && phase_end && !busy_l && !qpi_l && op_q == `SFRE_OP_FAST)
		|=> (st_q == sfre_pkg::ST_DUM) [*8] ##1 (st_q == sfre_pkg::ST_DAT))
		else $error("fast read dummy count wrong");
	AST_QPI_DEFAULT: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R8]
		(st_q == sfre_pkg::ST_ADR && phase_end && !busy_l && qpi_l && param_l == 2'h0 &&
		 op_q == `SFRE_OP_FAST) |=> (st_q == sfre_pkg::ST_DUM) [*2] ##1 (st_q == sfre_pkg::ST_DAT))
		else $error("four-wire default dummy count wrong");
	AST_DOUT_LANES: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R9]
		(st_q == sfre_pkg::ST_DAT && $past(st_q) == sfre_pkg::ST_DAT && op_q == `SFRE_OP_DOUT)
		|-> (lane_oe_q == 4'h3))
		else $error("dual output lanes not driven");
	AST_QOUT_LANES: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R12]
		(st_q == sfre_pkg::ST_DAT && $past(st_q) == sfre_pkg::ST_DAT && op_q == `SFRE_OP_QOUT)
		|-> (lane_oe_q == 4'hf))
		else $error("quad output lanes not driven");
	AST_QE_GATE: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R11]
		(st_q == sfre_pkg::ST_OPC && phase_end && !qpi_l && !qe_l && sh_d[7:0] == `SFRE_OP_QOUT)
		|=> (st_q == sfre_pkg::ST_IGN))
		else $error("quad output accepted without quad enable");
	AST_QIO_GATE: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R18]
		(st_q == sfre_pkg::ST_OPC && phase_end && !qpi_l && !qe_l && sh_d[7:0] == `SFRE_OP_QIO)
		|=> (st_q == sfre_pkg::ST_IGN))
		else $error("quad io accepted without quad enable");
	AST_QIO_DUMMY: assert property (@(posedge sclk_in) disable iff (!frm_rst_n) // [R17]
		(st_q == sfre_pkg::ST_MOD && phase_end && !qpi_l && op_q == `SFRE_OP_QIO)
		|=> (st_q == sfre_pkg::ST_DUM) [*4] ##1 (st_q == sfre_pkg::ST_DAT))
		else $error("quad io dummy count wrong");
	AST_CRM_SET: assert property (@(posedge sclk_in) disable iff (!rstn_in) // [R15]
		(st_q == sfre_pkg::ST_MOD && phase_end) |=> (crm_q == ($past(sh_d[5:4]) == 2'h2)))
		else $error("continuous read flag wrong");
	AST_QE_LOCK: assert property (@(posedge mclk_in) disable iff (!rstn_in) // [R22]
		(qpi_q && qe_wr_in) |=> (qe_q == $past(qe_q)))
		else $error("quad enable changed in four-wire mode");

	COV_READ_BYTE: cover property (@(posedge sclk_in) disable iff (!frm_rst_n)
		(st_q == sfre_pkg::ST_DAT && op_q == `SFRE_OP_READ && phase_end));
	COV_CRM_FRAME: cover property (@(posedge sclk_in) disable iff (!frm_rst_n) crm_start);
	COV_QIO_DATA: cover property (@(posedge sclk_in) disable iff (!frm_rst_n)
		(st_q == sfre_pkg::ST_DAT && op_q == `SFRE_OP_QIO && phase_end));
	COV_IGNORED: cover property (@(posedge sclk_in) disable iff (!frm_rst_n)
		(st_q == sfre_pkg::ST_IGN));
endmodule

//--- verification/sfre_host.sv
// SPI host model that drives the read engine's serial link
`timescale 1ns/100ps

module sfre_host (
	output logic            sclk_out,
	output logic            cs_n_out,
	output logic      [3:0] dq_out,
	output logic      [3:0] dq_oe_out,
	input  wire logic [3:0] dq_in
);
	logic [7:0] rx [0:7];

	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		dq_out = 4'h0;
		dq_oe_out = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode 0 clock: idle low, rising edge mid-bit
	task automatic clk1();
		#16 sclk_out = 1'b1;
		#16 sclk_out = 1'b0;
	endtask

	// MSB first, highest lane carries the upper bit
	task automatic shift(input logic [23:0] v, input int n, input int w);
		dq_oe_out = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
		for (int i = 0; i < n / w; i++) begin
			for (int j = 0; j < w; j++)
				dq_out[j] = v[n - w - i * w + j];
			clk1();
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Widths in lanes; ow of zero skips the opcode, mw of zero skips the mode byte
	task automatic xfer(input logic [7:0] op, input int ow, input logic [23:0] a, input int aw,
		input int mw, input logic [7:0] md, input int dum, input int dw, input int nb);
		logic [7:0] b;
		// Edges with select high let link configuration settle
		repeat (2) clk1();
		cs_n_out = 1'b0;
		if (ow != 0)
			shift({16'h0000, op}, 8, ow);
		shift(a, 24, aw);
		if (mw != 0)
			shift({16'h0000, md}, 8, mw);
		dq_oe_out = 4'h0;
		repeat (dum) clk1();
		for (int k = 0; k < nb; k++) begin
			b = 8'h00;
			repeat (8 / dw) begin
				#16 sclk_out = 1'b1;
				b = (b << dw) | ((dw == 1) ? {7'h00, dq_in[1]} :
					(dw == 2) ? {6'h00, dq_in[1:0]} : {4'h0, dq_in});
				#16 sclk_out = 1'b0;
			end
			rx[k] = b;
		end
		#16 cs_n_out = 1'b1;
	endtask

	// Ones on lane zero force mode bit 4 high
	task automatic quit(input int n);
		repeat (2) clk1();
		cs_n_out = 1'b0;
		dq_oe_out = 4'h1;
		dq_out = 4'h1;
		repeat (n) clk1();
		dq_oe_out = 4'h0;
		#16 cs_n_out = 1'b1;
	endtask
endmodule

//--- verification/testbench.sv
// Self-checking testbench of the serial flash read engine
`timescale 1ns/100ps
`include "sfre_cfg.svh"

module testbench;
	logic        mclk, rstn, busy, qe_wr, qe_wd, fw_en, fw_ex, prm_wr, srst, oe_seen, act_seen;
	logic [1:0]  prm_d;
	logic [3:0]  flt = 4'ha;
	logic [7:0]  md;
	logic [23:0] a;
	wire         sclk, cs_n, qe_o, fw_o, crm_o, act_o;
	wire  [1:0]  dsel;
	wire  [3:0]  h_dq, h_oe, dq, d_out, d_oe;
	wire  [7:0]  mem_d;
	wire  [23:0] addr;
	int          fail_count, total_checks;

	// Released lanes show a changing level
	assign dq = (d_oe & d_out) | (~d_oe & h_oe & h_dq) | (~d_oe & ~h_oe & flt);
	assign mem_d = mem_f(addr);

	sfre_engine u_sfre_engine (
		.mclk_in(mclk), .rstn_in(rstn), .busy_in(busy), .qe_wr_in(qe_wr),
		.qe_wdata_in(qe_wd), .four_wire_enter_in(fw_en), .four_wire_exit_in(fw_ex),
		.param_wr_in(prm_wr), .param_dummy_in(prm_d), .soft_reset_in(srst),
		.sclk_in(sclk), .cs_n_in(cs_n),
		.lane_zero_in(dq[0]), .lane_zero_out(d_out[0]), .lane_zero_oe_out(d_oe[0]),
		.lane_one_in(dq[1]), .lane_one_out(d_out[1]), .lane_one_oe_out(d_oe[1]),
		.lane_two_in(dq[2]), .lane_two_out(d_out[2]), .lane_two_oe_out(d_oe[2]),
		.lane_three_in(dq[3]), .lane_three_out(d_out[3]), .lane_three_oe_out(d_oe[3]),
		.mem_addr_out(addr), .mem_data_in(mem_d), .quad_lane_enable_bit_out(qe_o),
		.four_wire_command_mode_out(fw_o), .dummy_select_out(dsel),
		.continuous_read_out(crm_o), .frame_active_out(act_o)
	);

	sfre_host u_sfre_host (
		.sclk_out(sclk), .cs_n_out(cs_n), .dq_out(h_dq), .dq_oe_out(h_oe), .dq_in(dq)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] mem_f(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3c;
	endfunction

	task automatic chk(input logic c, input string m);
		total_checks++;
		if (c !== 1'b1) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic rd_chk(input logic [23:0] x, input int n);
		for (int i = 0; i < n; i++)
			chk(u_sfre_host.rx[i] === mem_f(x + 24'(i)), "read data");
	endtask

	// Pulse bits: {soft reset, param write, exit, enter, quad enable write}
	task automatic ctl(input logic [4:0] s, input logic [1:0] p, input logic q);
		@(posedge mclk);
		{srst, prm_wr, fw_ex, fw_en, qe_wr} <= s;
		prm_d <= p;
		qe_wd <= q;
		@(posedge mclk);
		{srst, prm_wr, fw_ex, fw_en, qe_wr} <= 5'h00;
		repeat (3) @(posedge mclk);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(sclk)
		flt = ~flt;

	always @(posedge sclk)
		if (d_oe !== 4'h0)
			oe_seen = 1'b1;

	// Records that frame activity reached the system clock
	always @(posedge mclk)
		if (act_o === 1'b1)
			act_seen <= 1'b1;

	initial begin
		#1000000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		print_verdict();
	end

	initial begin
		logic [7:0] ops [0:2];
		logic [1:0] e;
		int         w;
		ops = '{`SFRE_OP_FAST, `SFRE_OP_DOUT, `SFRE_OP_QOUT};
		{rstn, busy, qe_wr, qe_wd, fw_en, fw_ex, prm_wr, srst, oe_seen, act_seen} = 10'h000;
		prm_d = 2'h0;
		fail_count = 0;
		total_checks = 0;
		void'($urandom(17369));
		repeat (10) @(posedge mclk);
		rstn <= 1'b1;
		repeat (2) @(posedge mclk);
		chk({qe_o, fw_o, dsel, crm_o} === 5'h00, "reset values");
		a = 24'hfffffd;
		u_sfre_host.xfer(`SFRE_OP_READ, 1, a, 1, 0, 8'h00, 0, 1, 5);
		rd_chk(a, 5);
		chk(addr === 24'(a + 24'h000005), "address after five bytes");
		$display("test plain read done");
		ctl(5'h01, 2'h0, 1'b1);
		chk(qe_o === 1'b1, "quad enable write");
		chk(act_seen === 1'b1 && act_o === 1'b0, "frame activity");
		for (int i = 0; i < 3; i++) begin
			a = 24'($urandom);
			u_sfre_host.xfer(ops[i], 1, a, 1, 0, 8'h00, 8, 1 << i, 3);
			rd_chk(a, 3);
		end
		$display("test fast reads done");
		busy <= 1'b1;
		repeat (2) @(posedge mclk);
		oe_seen = 1'b0;
		u_sfre_host.xfer(`SFRE_OP_FAST, 1, a, 1, 0, 8'h00, 8, 1, 2);
		chk(oe_seen === 1'b0, "read taken while busy");
		busy <= 1'b0;
		$display("test busy done");
		for (int i = 0; i < 2; i++) begin
			w = 2 << i;
			md = (8'($urandom) & 8'hcf) | 8'h20;
			a = 24'($urandom);
			u_sfre_host.xfer(i ? `SFRE_OP_QIO : `SFRE_OP_DIO, 1, a, w, w, md, 4 * i, w, 3);
			rd_chk(a, 3);
			repeat (4) @(posedge mclk);
			chk(crm_o === 1'b1, "opcode skip not armed");
			a = 24'($urandom);
			u_sfre_host.xfer(8'h00, 0, a, w, w, md ^ 8'h0f, 4 * i, w, 3);
			rd_chk(a, 3);
			u_sfre_host.quit(i ? 8 : 16);
			repeat (4) @(posedge mclk);
			chk(crm_o === 1'b0, "opcode skip not cleared");
		end
		$display("test continuous read done");
		ctl(5'h01, 2'h0, 1'b0);
		ctl(5'h02, 2'h0, 1'b0);
		chk({qe_o, fw_o} === 2'b00, "four-wire entered without quad enable");
		oe_seen = 1'b0;
		u_sfre_host.xfer(`SFRE_OP_QOUT, 1, a, 1, 0, 8'h00, 8, 4, 2);
		u_sfre_host.xfer(`SFRE_OP_QIO, 1, a, 4, 4, 8'h00, 4, 4, 2);
		chk(oe_seen === 1'b0, "quad read taken without quad enable");
		$display("test quad refusal done");
		ctl(5'h01, 2'h0, 1'b1);
		ctl(5'h02, 2'h0, 1'b0);
		ctl(5'h01, 2'h0, 1'b0);
		chk({qe_o, fw_o} === 2'b11, "four-wire entry or quad enable lock");
		for (int c = 0; c < 5; c++) begin
			// Last pass: soft reset together with a parameter write
			ctl((c < 4) ? 5'h08 : 5'h18, (c < 4) ? 2'(c) : 2'h3, 1'b0);
			e = (c < 4) ? 2'(c) : 2'h0;
			chk(dsel === e, "dummy select");
			a = 24'($urandom);
			u_sfre_host.xfer(`SFRE_OP_FAST, 4, a, 4, 0, 8'h00, 2 * (int'(e) + 1), 4, 3);
			rd_chk(a, 3);
		end
		// Four-wire quad I/O at default select: data follows the mode byte
		a = 24'($urandom);
		u_sfre_host.xfer(`SFRE_OP_QIO, 4, a, 4, 4, 8'h00, 0, 4, 2);
		rd_chk(a, 2);
		oe_seen = 1'b0;
		u_sfre_host.xfer(`SFRE_OP_READ, 4, a, 4, 0, 8'h00, 0, 4, 2);
		chk(oe_seen === 1'b0, "plain read taken in four-wire mode");
		ctl(5'h04, 2'h0, 1'b0);
		chk(fw_o === 1'b0, "four-wire exit");
		$display("test four-wire mode done");
		print_verdict();
	end
endmodule
